// *** rtl/fault_policy_cfg.svh ***
// constants for the output fault response policy block
`ifndef FAULT_POLICY_CFG_SVH
`define FAULT_POLICY_CFG_SVH

// ---------------------------------------------------------------
// command codes and reset values
// ---------------------------------------------------------------
`define CMD_UV_ACTION 8'h45
`define CMD_OC_ACTION 8'h47
`define CMD_TON_ACTION 8'h63
`define UV_ACTION_RESET 8'hb8
`define OC_ACTION_RESET 8'h00
`define TON_ACTION_RESET 8'hb8

// ---------------------------------------------------------------
// response byte fields
// ---------------------------------------------------------------
`define RESP_HI 7
`define RESP_LO 6
`define RETRY_HI 5
`define RETRY_LO 3
`define DELAY_HI 2
`define DELAY_LO 0

// ---------------------------------------------------------------
// status bit positions
// ---------------------------------------------------------------
`define SB_NONE_ABOVE 0
`define SB_CML 1
`define SW_VOUT 15
`define SV_UV_FAULT 4
`define SV_TON_MAX 2

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLOCK_HZ 10000000
`define DELAY_UNIT_NS 10000
`define DELAY_UNIT_CYCLES ((`DELAY_UNIT_NS * (`CLOCK_HZ / 1000000)) / 1000)

`endif

// *** rtl/fault_policy_pkg.sv ***
// types for the output fault response policy block
package fault_policy_pkg;

    // response field encodings
    typedef enum logic [1:0]
    {
        RESP_IGNORE = 2'h0,
        RESP_DEGLITCH = 2'h1,
        RESP_SHUTDOWN = 2'h2,
        RESP_BAD = 2'h3
    } response_t;

    // channel sequencing status from the channel sequencer
    typedef struct packed
    {
        logic active;
        logic ton_delay_done;
        logic ton_rise_done;
        logic toff_fall;
        logic uv_reached;
        logic oc_present;
        logic ton_max_reached;
    } seq_status_t;

    // clear events from the command decoder
    typedef struct packed
    {
        logic clear_faults;
        logic off_on;
        logic restore_user;
        logic soft_reset;
    } clear_evt_t;

    // policy state, gray coded along idle-delay-off-wait
    typedef enum logic [1:0]
    {
        ST_RUN = 2'h0,
        ST_DELAY = 2'h1,
        ST_OFF = 2'h3,
        ST_RETRY = 2'h2
    } policy_state_t;

endpackage

// *** rtl/delay_timer.sv ***
// cycle counter in 10 us ticks for the deglitch delay
`include "fault_policy_cfg.svh"
module delay_timer
(
    input wire logic clock,
    input wire logic reset,
    input wire logic start,
    input wire logic run,
    input wire logic [2:0] ticks,
    output logic expired
);
    localparam int UNIT = `DELAY_UNIT_CYCLES;
    logic [6:0] sub;
    logic [2:0] left;

    // -----------------------------------------------------------
    // tick prescaler and down counter
    // -----------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (reset || start || !run)
        begin
            sub <= 7'h00;
            left <= start ? ticks : 3'h0;
            expired <= 1'b0;
        end
        else if (left == 3'h0)
        begin
            expired <= 1'b1; // zero delay acts next cycle
        end
        else if (sub == 7'(UNIT - 1))
        begin
            sub <= 7'h00;
            left <= left - 3'h1;
        end
        else
        begin
            sub <= sub + 7'h01;
        end
    end
endmodule

// *** rtl/retry_timer.sv ***
// spacing counter between restart attempts
module retry_timer
(
    input wire logic clock,
    input wire logic reset,
    input wire logic start,
    input wire logic [15:0] interval,
    output logic done
);
    logic [15:0] count;
    logic busy;

    // -----------------------------------------------------------
    // count the programmed interval, pulse done at the end
    // -----------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            count <= 16'h0000;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else if (start)
        begin
            count <= interval;
            busy <= 1'b1;
            done <= 1'b0;
        end
        else if (busy && count == 16'h0000)
        begin
            busy <= 1'b0;
            done <= 1'b1;
        end
        else
        begin
            count <= busy ? count - 16'h0001 : count;
            done <= 1'b0;
        end
    end
endmodule

// *** rtl/fault_policy.sv ***
// per-channel undervoltage and turn-on timeout fault response policy
`include "fault_policy_cfg.svh"

// Behaviour
// - uv fault sets status bits and alert
// - uv masked until turn-on criteria met
// - uv masked while channel inactive
// - uv masked during rise and fall
// - response 00 ignores fault, still reports
// - response 01 waits delay then retry policy
// - response 10 shuts down immediately, retry policy
// - response 11 write to uv or turn-on byte raises cml fault
// - retry 000 stays off after shutdown until a clear event
// - other retry restarts continuously at interval
// - delay field counts 10 us units
// - fault bits sticky until clear events
// - turn-on timeout sets status and alert
// - turn-on max of zero disables timeout
// - discontinuous mode until turn-on max exceeded
// - overcurrent action byte at 0x47, reset 00
// - undervoltage action byte at 0x45, reset b8
module fault_policy
(
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic WR_STROBE,
    input wire logic [7:0] WR_CODE,
    input wire logic [7:0] WR_DATA,
    input wire logic [7:0] RD_CODE,
    output logic [7:0] RD_DATA,
    input wire logic [15:0] TON_MAX_LIMIT,
    input wire logic [15:0] RESTART_INTERVAL_SETTING,
    input wire fault_policy_pkg::seq_status_t SEQ,
    input wire logic UV_DETECT,
    input wire logic TON_MAX_FAULT,
    input wire logic ALERT_MASK,
    input wire fault_policy_pkg::clear_evt_t CLR,
    output logic OUTPUT_ENABLE,
    output logic RESTART_REQ,
    output logic DISCONTINUOUS,
    output logic UV_QUALIFIED,
    output logic [7:0] STATUS_BYTE,
    output logic [15:0] STATUS_WORD,
    output logic [7:0] STATUS_VOUT,
    output logic ALERT
);
    logic [7:0] uv_action;
    logic [7:0] oc_action;
    logic [7:0] ton_action;
    fault_policy_pkg::policy_state_t state;
    logic uv_live;
    logic uv_event;
    logic ton_event;
    logic bad_write;
    logic clear_any;
    logic delay_expired;
    logic retry_done;
    logic retry_start;
    logic dly_start;

    // field decode shared by both action bytes
    function automatic fault_policy_pkg::response_t resp_of(input logic [7:0] b);
        resp_of = fault_policy_pkg::response_t'(b[`RESP_HI:`RESP_LO]);
    endfunction

    function automatic logic [2:0] retry_of(input logic [7:0] b);
        retry_of = b[`RETRY_HI:`RETRY_LO];
    endfunction

    // -----------------------------------------------------------
    // action byte registers
    // -----------------------------------------------------------
    // the unsupported response is rejected for the uv and turn-on bytes so the old policy stays; the overcurrent byte takes it
    assign bad_write = WR_STROBE && (WR_CODE == `CMD_UV_ACTION || WR_CODE == `CMD_TON_ACTION)
                       && resp_of(WR_DATA) == fault_policy_pkg::RESP_BAD;
    always_ff @(posedge CLOCK)
    begin
        if (RESET || CLR.restore_user || CLR.soft_reset)
        begin
            uv_action <= `UV_ACTION_RESET;
            oc_action <= `OC_ACTION_RESET;
            ton_action <= `TON_ACTION_RESET;
        end
        else if (WR_STROBE && !bad_write)
        begin
            if (WR_CODE == `CMD_UV_ACTION)
                uv_action <= WR_DATA;
            if (WR_CODE == `CMD_OC_ACTION)
                oc_action <= WR_DATA;
            if (WR_CODE == `CMD_TON_ACTION)
                ton_action <= WR_DATA;
        end
    end

    // read mux, unknown codes read zero
    always_ff @(posedge CLOCK)
    begin
        if (RESET)
            RD_DATA <= 8'h00;
        else if (RD_CODE == `CMD_UV_ACTION)
            RD_DATA <= uv_action;
        else if (RD_CODE == `CMD_OC_ACTION)
            RD_DATA <= oc_action;
        else if (RD_CODE == `CMD_TON_ACTION)
            RD_DATA <= ton_action;
        else
            RD_DATA <= 8'h00;
    end

    // -----------------------------------------------------------
    // undervoltage masking
    // -----------------------------------------------------------
    assign uv_live = SEQ.active && SEQ.ton_max_reached && SEQ.ton_delay_done && SEQ.ton_rise_done
                     && SEQ.uv_reached && !SEQ.oc_present
                     && !SEQ.toff_fall;
    assign uv_event = uv_live && UV_DETECT;
    assign ton_event = TON_MAX_FAULT && TON_MAX_LIMIT != 16'h0000;
    assign clear_any = CLR.clear_faults || CLR.off_on || CLR.restore_user || CLR.soft_reset;

    always_ff @(posedge CLOCK)
    begin
        if (RESET)
            UV_QUALIFIED <= 1'b0;
        else
            UV_QUALIFIED <= uv_live;
    end

    // discontinuous switching until the turn-on limit is passed
    always_ff @(posedge CLOCK)
    begin
        if (RESET)
            DISCONTINUOUS <= 1'b1;
        else
            DISCONTINUOUS <= SEQ.active && !SEQ.ton_max_reached;
    end

    // -----------------------------------------------------------
    // sticky status, set wins over clear
    // -----------------------------------------------------------
    always_ff @(posedge CLOCK)
    begin
        if (RESET)
        begin
            STATUS_BYTE <= 8'h00;
            STATUS_WORD <= 16'h0000;
            STATUS_VOUT <= 8'h00;
        end
        else
        begin
            if (clear_any)
            begin
                STATUS_BYTE <= 8'h00;
                STATUS_WORD <= 16'h0000;
                STATUS_VOUT <= 8'h00;
            end
            if (uv_event || ton_event)
            begin
                STATUS_BYTE[`SB_NONE_ABOVE] <= 1'b1;
                STATUS_WORD[`SW_VOUT] <= 1'b1;
                STATUS_WORD[`SB_NONE_ABOVE] <= 1'b1;
            end
            if (uv_event)
                STATUS_VOUT[`SV_UV_FAULT] <= 1'b1;
            if (ton_event)
                STATUS_VOUT[`SV_TON_MAX] <= 1'b1;
            if (bad_write)
            begin
                STATUS_BYTE[`SB_CML] <= 1'b1;
                STATUS_WORD[`SB_CML] <= 1'b1;
            end
        end
    end

    // alert follows any sticky bit unless masked
    always_ff @(posedge CLOCK)
    begin
        if (RESET)
            ALERT <= 1'b0;
        else
            ALERT <= !ALERT_MASK && (STATUS_BYTE != 8'h00 || uv_event || ton_event || bad_write);
    end

    // -----------------------------------------------------------
    // response state machine
    // -----------------------------------------------------------
    // turn-on timeout takes response and delay from its own byte, retry from the uv byte; both share one output path
    fault_policy_pkg::policy_state_t next_state;
    logic [7:0] act;
    always_comb
    begin
        act = ton_event ? ton_action : uv_action;
        next_state = state;
        dly_start = 1'b0;
        retry_start = 1'b0;
        case (state)
            fault_policy_pkg::ST_RUN:
            begin
                if ((uv_event || ton_event) && resp_of(act) == fault_policy_pkg::RESP_DEGLITCH)
                begin
                    next_state = fault_policy_pkg::ST_DELAY;
                    dly_start = 1'b1;
                end
                else if ((uv_event || ton_event) && resp_of(act) == fault_policy_pkg::RESP_SHUTDOWN)
                begin
                    next_state = fault_policy_pkg::ST_OFF;
                end
                // response 00: stay running, status still set
            end
            fault_policy_pkg::ST_DELAY:
            begin
                if (!UV_DETECT && !ton_event)
                    next_state = fault_policy_pkg::ST_RUN;
                else if (delay_expired)
                    next_state = fault_policy_pkg::ST_OFF;
            end
            fault_policy_pkg::ST_OFF:
            begin
                if (retry_of(uv_action) != 3'h0)
                begin
                    next_state = fault_policy_pkg::ST_RETRY;
                    retry_start = 1'b1;
                end
                else if (clear_any)
                    next_state = fault_policy_pkg::ST_RUN;
            end
            fault_policy_pkg::ST_RETRY:
            begin
                if (retry_done)
                    next_state = fault_policy_pkg::ST_RUN;
            end
            default:
                next_state = fault_policy_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge CLOCK)
    begin
        if (RESET || !SEQ.active)
            state <= fault_policy_pkg::ST_RUN; // commanded off ends retry
        else
            state <= next_state;
    end

    // output drive and one-cycle restart request
    always_ff @(posedge CLOCK)
    begin
        if (RESET)
        begin
            OUTPUT_ENABLE <= 1'b1;
            RESTART_REQ <= 1'b0;
        end
        else
        begin
            OUTPUT_ENABLE <= next_state == fault_policy_pkg::ST_RUN
                             || next_state == fault_policy_pkg::ST_DELAY;
            RESTART_REQ <= state == fault_policy_pkg::ST_RETRY && retry_done;
        end
    end

    delay_timer u_delay
    (
        .clock(CLOCK),
        .reset(RESET),
        .start(dly_start),
        .run(state == fault_policy_pkg::ST_DELAY),
        .ticks(act[`DELAY_HI:`DELAY_LO]),
        .expired(delay_expired)
    );

    retry_timer u_retry
    (
        .clock(CLOCK),
        .reset(RESET),
        .start(retry_start),
        .interval(RESTART_INTERVAL_SETTING),
        .done(retry_done)
    );

    // -----------------------------------------------------------
    // checks
    // -----------------------------------------------------------
    property p_cml;
        @(posedge CLOCK) disable iff (RESET)
        bad_write |=> STATUS_BYTE[`SB_CML];
    endproperty
    a_cml: assert property (p_cml) else $error("cml bit not set");

    property p_uv_status;
        @(posedge CLOCK) disable iff (RESET)
        uv_event |=> STATUS_VOUT[`SV_UV_FAULT] && STATUS_WORD[`SW_VOUT];
    endproperty
    a_uv_status: assert property (p_uv_status) else $error("uv status missing");

    property p_inactive;
        @(posedge CLOCK) disable iff (RESET)
        !SEQ.active |=> !UV_QUALIFIED;
    endproperty
    a_inactive: assert property (p_inactive) else $error("uv live while inactive");

    property p_fall;
        @(posedge CLOCK) disable iff (RESET)
        SEQ.toff_fall |=> !UV_QUALIFIED;
    endproperty
    a_fall: assert property (p_fall) else $error("uv live during fall");

    property p_ignore;
        @(posedge CLOCK) disable iff (RESET)
        state == fault_policy_pkg::ST_RUN && SEQ.active && uv_event && !ton_event
        && resp_of(uv_action) == fault_policy_pkg::RESP_IGNORE |=> OUTPUT_ENABLE;
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignored fault shut down");

    property p_shut;
        @(posedge CLOCK) disable iff (RESET)
        state == fault_policy_pkg::ST_RUN && SEQ.active && uv_event && !ton_event
        && resp_of(uv_action) == fault_policy_pkg::RESP_SHUTDOWN |=> !OUTPUT_ENABLE;
    endproperty
    a_shut: assert property (p_shut) else $error("no immediate shutdown");

    property p_sticky;
        @(posedge CLOCK) disable iff (RESET)
        STATUS_VOUT[`SV_UV_FAULT] && !clear_any |=> STATUS_VOUT[`SV_UV_FAULT];
    endproperty
    a_sticky: assert property (p_sticky) else $error("fault bit dropped");

    property p_latch_off;
        @(posedge CLOCK) disable iff (RESET)
        state == fault_policy_pkg::ST_OFF && retry_of(uv_action) == 3'h0 && !clear_any && SEQ.active
        |=> state == fault_policy_pkg::ST_OFF;
    endproperty
    a_latch_off: assert property (p_latch_off) else $error("restart without retry");

    property p_ton_zero;
        @(posedge CLOCK) disable iff (RESET)
        TON_MAX_LIMIT == 16'h0000 && !uv_event && !bad_write && STATUS_BYTE == 8'h00
        |=> STATUS_VOUT[`SV_TON_MAX] == 1'b0 || $past(STATUS_VOUT[`SV_TON_MAX]);
    endproperty
    a_ton_zero: assert property (p_ton_zero) else $error("timeout with zero limit");
endmodule

// *** testbench/seq_model.sv ***
// channel sequencer model driving the ramp status levels
module seq_model
(
    input wire logic clock,
    input wire logic reset,
    input wire logic power,
    input wire logic oc,
    output fault_policy_pkg::seq_status_t seq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] step;

    // ramp position, climbs while powered and falls back after
    always_ff @(posedge clock)
    begin
        if (reset)
            step <= 4'h0;
        else if (power && step != 4'hf)
            step <= step + 4'h1;
        else if (!power && step != 4'h0)
            step <= step - 4'h1;
    end

    // status levels, the turn-on limit lands two steps after the threshold
    always_comb
    begin
        seq.active = power || step != 4'h0;
        seq.ton_delay_done = step >= 4'h2;
        seq.ton_rise_done = power && step >= 4'h6;
        seq.toff_fall = !power && step != 4'h0;
        seq.uv_reached = step >= 4'h6;
        seq.oc_present = oc;
        seq.ton_max_reached = step >= 4'h8;
    end
endmodule

// *** testbench/fault_policy_tb_top.sv ***
// self-checking bench for the output fault response policy
module fault_policy_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic wr_strobe = 1'b0;
    logic [7:0] wr_code = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] rd_code = 8'h00;
    logic [7:0] rd_data;
    logic [15:0] ton_max_limit = 16'h0064;
    logic [15:0] retry_gap = 16'h0014;
    fault_policy_pkg::seq_status_t seq;
    fault_policy_pkg::clear_evt_t clr = '0;
    logic uv = 1'b0;
    logic ton_fault = 1'b0;
    logic alert_mask = 1'b0;
    logic power = 1'b0;
    logic oc = 1'b0;
    logic oe, restart_req, discontinuous, uv_qualified, alert;
    logic [7:0] status_byte, status_vout;
    logic [15:0] status_word;
    int num_errors = 0;
    int checks = 0;

    // ---------------------------------------------------------------
    // clock, design and sequencer
    // ---------------------------------------------------------------
    always #50 clock = ~clock;

    fault_policy u_fault_policy (.CLOCK(clock), .RESET(reset), .WR_STROBE(wr_strobe),
        .WR_CODE(wr_code), .WR_DATA(wr_data), .RD_CODE(rd_code), .RD_DATA(rd_data),
        .TON_MAX_LIMIT(ton_max_limit), .RESTART_INTERVAL_SETTING(retry_gap), .SEQ(seq),
        .UV_DETECT(uv), .TON_MAX_FAULT(ton_fault), .ALERT_MASK(alert_mask), .CLR(clr),
        .OUTPUT_ENABLE(oe), .RESTART_REQ(restart_req), .DISCONTINUOUS(discontinuous),
        .UV_QUALIFIED(uv_qualified), .STATUS_BYTE(status_byte), .STATUS_WORD(status_word),
        .STATUS_VOUT(status_vout), .ALERT(alert));

    seq_model u_seq_model (.clock(clock), .reset(reset), .power(power), .oc(oc), .seq(seq));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    // single strobe, released at the following falling edge
    task automatic wr(input logic [7:0] code, input logic [7:0] data);
        @(negedge clock);
        wr_strobe = 1'b1;
        wr_code = code;
        wr_data = data;
        @(negedge clock);
        wr_strobe = 1'b0;
    endtask

    task automatic rd(input logic [7:0] code, input logic [7:0] exp);
        @(negedge clock);
        rd_code = code;
        @(negedge clock);
        chk("read data", {8'h00, exp}, {8'h00, rd_data});
    endtask

    task automatic clear(input logic [3:0] ev);
        @(negedge clock);
        clr = fault_policy_pkg::clear_evt_t'(ev);
        @(negedge clock);
        clr = '0;
        cyc(2);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic regs;
        rd(8'h45, 8'hb8);
        rd(8'h47, 8'h00);
        wr(8'h47, 8'h3c);
        rd(8'h47, 8'h3c);
        rd(8'h12, 8'h00);
        wr(8'h47, 8'h00);
        wr(8'h45, 8'hc0);
        rd(8'h45, 8'hb8);
        chk("cml bit", 16'h1, {15'h0, status_byte[1]});
        chk("cml word bit", 16'h1, {15'h0, status_word[1]});
        clear(4'h8);
        wr(8'h63, 8'hf8);
        rd(8'h63, 8'hb8);
        chk("cml bit", 16'h1, {15'h0, status_byte[1]});
        clear(4'h8);
    endtask

    // detection masked while inactive, during rise and under overcurrent
    task automatic masking;
        wr(8'h45, 8'h00);
        uv = 1'b1;
        cyc(10);
        chk("uv while inactive", 16'h0, {8'h0, status_vout});
        chk("qualified while inactive", 16'h0, {15'h0, uv_qualified});
        power = 1'b1;
        cyc(4);
        chk("uv during rise", 16'h0, {8'h0, status_vout});
        cyc(3);
        // step seven: only the turn-on limit still holds detection off
        chk("uv before turn-on limit", 16'h0, {8'h0, status_vout});
        chk("discontinuous", 16'h1, {15'h0, discontinuous});
        oc = 1'b1;
        cyc(17);
        chk("uv under oc", 16'h0, {8'h0, status_vout});
        chk("qualified under oc", 16'h0, {15'h0, uv_qualified});
        chk("discontinuous", 16'h0, {15'h0, discontinuous});
        oc = 1'b0;
        cyc(5);
        uv = 1'b0;
        chk("uv bit", 16'h10, {8'h0, status_vout});
        chk("qualified", 16'h1, {15'h0, uv_qualified});
        chk("vout word bit", 16'h1, {15'h0, status_word[15]});
        chk("catch-all bit", 16'h1, {15'h0, status_byte[0]});
        chk("alert", 16'h1, {15'h0, alert});
        chk("output kept", 16'h1, {15'h0, oe});
    endtask

    // every clear event drops a sticky bit
    task automatic sticky;
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h45, 8'h00);
            uv = 1'b1;
            cyc(4);
            uv = 1'b0;
            cyc(20);
            chk("sticky uv", 16'h1, {15'h0, status_vout[4]});
            clear(4'h1 << k);
            chk("cleared uv", 16'h0, {15'h0, status_vout[4]});
        end
        // falling ramp keeps detection off, then a masked live fault
        alert_mask = 1'b1;
        power = 1'b0;
        uv = 1'b1;
        cyc(3);
        chk("uv during fall", 16'h0, {8'h0, status_vout});
        chk("qualified during fall", 16'h0, {15'h0, uv_qualified});
        power = 1'b1;
        cyc(4);
        uv = 1'b0;
        chk("masked fault bit", 16'h10, {8'h0, status_vout});
        chk("masked alert", 16'h0, {15'h0, alert});
        clear(4'h8);
        alert_mask = 1'b0;
    endtask

    task automatic shutdown;
        int n = 0;
        wr(8'h45, 8'h80);
        uv = 1'b1;
        cyc(3);
        chk("output off", 16'h0, {15'h0, oe});
        repeat (300)
        begin
            @(negedge clock);
            if (restart_req === 1'b1)
                n++;
        end
        chk("no restart", 16'h0, n[15:0]);
        chk("output held off", 16'h0, {15'h0, oe});
        uv = 1'b0;
        clear(4'h8);
        chk("output back", 16'h1, {15'h0, oe});
    endtask

    // retry spacing is the interval plus a couple of cycles
    task automatic retry;
        int n = 0;
        wr(8'h45, 8'hb8);
        uv = 1'b1;
        cyc(3);
        chk("output off", 16'h0, {15'h0, oe});
        uv = 1'b0;
        while (restart_req !== 1'b1 && n < 40)
        begin
            @(negedge clock);
            n++;
        end
        chk("retry spacing", 16'h1, {15'h0, n >= 15 && n <= 24});
        cyc(2);
        chk("output restarted", 16'h1, {15'h0, oe});
        n = 0;
        uv = 1'b1;
        repeat (150)
        begin
            @(negedge clock);
            if (restart_req === 1'b1)
                n++;
        end
        chk("repeated retries", 16'h1, {15'h0, n >= 4});
        uv = 1'b0;
        clear(4'h8);
    endtask

    // two delay units of 100 cycles each before shutting down
    task automatic deglitch;
        wr(8'h45, 8'h42);
        uv = 1'b1;
        cyc(50);
        uv = 1'b0;
        cyc(300);
        chk("brief fault rides", 16'h1, {15'h0, oe});
        clear(4'h8);
        uv = 1'b1;
        cyc(190);
        chk("still running", 16'h1, {15'h0, oe});
        cyc(30);
        chk("deglitched off", 16'h0, {15'h0, oe});
        uv = 1'b0;
        clear(4'h8);
    endtask

    task automatic turn_on_timeout;
        ton_max_limit = 16'h0000;
        ton_fault = 1'b1;
        cyc(4);
        ton_fault = 1'b0;
        chk("timeout disabled", 16'h0, {8'h0, status_vout});
        ton_max_limit = 16'h0064;
        ton_fault = 1'b1;
        cyc(4);
        ton_fault = 1'b0;
        chk("timeout bit", 16'h4, {8'h0, status_vout});
        chk("vout word bit", 16'h1, {15'h0, status_word[15]});
        chk("catch-all bit", 16'h1, {15'h0, status_byte[0]});
        chk("alert", 16'h1, {15'h0, alert});
        clear(4'h8);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // main sequence, reset held for five cycles
    initial
    begin
        cyc(5);
        reset = 1'b0;
        regs();
        masking();
        sticky();
        shutdown();
        retry();
        deglitch();
        turn_on_timeout();
        tally_and_finish();
    end

    // watchdog, about four times the expected run length
    initial
    begin
        repeat (5000) @(posedge clock);
        num_errors++;
        tally_and_finish();
    end
endmodule
